// >>> rtl/iobx_core.sv
// iobx_core: executes increment-skip, increment, or-literal, or-register and
// absolute jump for an 8-bit accumulator core with 128 file registers.
// assumes the fetch logic presents the instruction at pc_out each cycle.
//
// Summary of operation
// - Increment-skip adds one to the addressed file register, writes it to acc (d=0) or the file (d=1), no flags.
// - A zero result of increment-skip discards the next instruction as a no-op, costing two instruction cycles.
// - The jump loads its 11-bit field into pc<10:0> and page latch <4:3> into pc<12:11>, over two cycles.
// - Or-literal places acc OR the 8-bit literal in acc and updates the zero flag.
// - Increment adds one to the addressed file register, sends it by the d bit and updates the zero flag.
// - Or-register ORs acc with the addressed file register, sends it by the d bit and updates the zero flag.
`timescale 1ns/10ps
module iobx_core
  import iobx_pkg::*;
#(
  parameter int FILE_DEPTH = 128
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [IOBX_INSTR_W-1:0] instr,
  input wire logic [IOBX_DATA_W-1:0] pc_page_latch,
  output logic instr_ready,
  output logic [IOBX_PC_W-1:0] pc_out,
  output logic [IOBX_DATA_W-1:0] acc_out,
  output logic zero_flag,
  output logic file_wr_valid,
  output logic [IOBX_FADDR_W-1:0] file_wr_addr,
  output logic [IOBX_DATA_W-1:0] file_wr_data,
  output logic discard_pulse
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [IOBX_DATA_W-1:0] file_q [FILE_DEPTH];
  logic [IOBX_DATA_W-1:0] acc_q, acc_d;
  logic zero_q, zero_d;
  logic [IOBX_PC_W-1:0] pc_q, pc_d;
  logic flush_q, flush_d;
  logic ready_q;
  logic wr_q, wr_d;
  logic [IOBX_FADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [IOBX_DATA_W-1:0] wr_data_q, wr_data_d;
  logic disc_q, disc_d;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic op_match(input logic [13:0] word, input logic [13:0] mask,
                                    input logic [13:0] pat);
    op_match = ((word & mask) == pat);
  endfunction

  logic take, executes, file_op, writes_file;
  logic is_inc_skip, is_inc, is_or_reg, is_or_lit, is_jump;
  logic dest_file;
  logic [IOBX_FADDR_W-1:0] faddr;
  logic [IOBX_DATA_W-1:0] fval, lit, result;
  logic res_zero;
  iobx_alu_op_t alu_op;

  assign take = instr_valid && ready_q;
  assign is_inc_skip = op_match(instr, IOBX_MASK_FILE, IOBX_OP_INC_SKIP);
  assign is_inc = op_match(instr, IOBX_MASK_FILE, IOBX_OP_INC_REG);
  assign is_or_reg = op_match(instr, IOBX_MASK_FILE, IOBX_OP_OR_REG);
  assign is_or_lit = op_match(instr, IOBX_MASK_LIT, IOBX_OP_OR_LIT);
  assign is_jump = op_match(instr, IOBX_MASK_JUMP, IOBX_OP_JUMP);
  assign dest_file = instr[IOBX_DEST_BIT];
  assign faddr = instr[IOBX_FADDR_LSB +: IOBX_FADDR_W];
  assign lit = instr[IOBX_LIT_LSB +: IOBX_DATA_W];
  assign file_op = is_inc_skip || is_inc || is_or_reg;
  // addresses past the implemented depth read as zero
  assign fval = (int'(faddr) < FILE_DEPTH) ? file_q[faddr] : '0;

  always_comb begin
    if (is_inc_skip || is_inc) begin
      alu_op = IOBX_ALU_INC;
    end else if (is_or_lit) begin
      alu_op = IOBX_ALU_OR_LIT;
    end else if (is_or_reg) begin
      alu_op = IOBX_ALU_OR_REG;
    end else begin
      alu_op = IOBX_ALU_NONE;
    end
  end

  iobx_alu u_alu (
    .op(alu_op),
    .acc(acc_q),
    .fval(fval),
    .lit(lit),
    .result(result),
    .is_zero(res_zero)
  );

  // ----------------------------------------------------------------------
  // sequencing: program counter and the word behind a branch
  // ----------------------------------------------------------------------
  // the second cycle of a taken skip or a jump is one dropped word rather
  // than a stall, so the fetch side never has to hold a word back
  assign executes = take && !flush_q;

  always_comb begin
    pc_d = pc_q;
    flush_d = flush_q;
    disc_d = 1'b0;
    if (take) begin
      pc_d = IOBX_PC_W'(pc_q + 1'b1);
      if (flush_q) begin
        // the fetched word behind a taken skip or a jump becomes a no-op
        flush_d = 1'b0;
        disc_d = 1'b1;
      end else if (is_jump) begin
        pc_d = {pc_page_latch[IOBX_PAGE_HI:IOBX_PAGE_LO], instr[IOBX_JUMP_LSB +: IOBX_JUMP_W]};
        flush_d = 1'b1;
      end else if (is_inc_skip && res_zero) begin
        flush_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= IOBX_PC_RST;
      flush_q <= 1'b0;
      ready_q <= 1'b0;
      disc_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      flush_q <= flush_d;
      ready_q <= 1'b1;
      disc_q <= disc_d;
    end
  end

  // ----------------------------------------------------------------------
  // accumulator and zero flag
  // ----------------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    if (executes) begin
      if (file_op && !dest_file) begin
        acc_d = result;
      end
      if (is_or_lit) begin
        acc_d = result;
      end
      // increment-skip leaves the flag alone; the other three track the result
      if (is_inc || is_or_reg || is_or_lit) begin
        zero_d = res_zero;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= IOBX_ACC_RST;
      zero_q <= IOBX_ZERO_RST;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
    end
  end

  // ----------------------------------------------------------------------
  // file write port
  // ----------------------------------------------------------------------
  // a dropped word must leave the file alone, so only executed words write
  assign writes_file = executes && file_op && dest_file;

  always_comb begin
    wr_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (writes_file) begin
      wr_d = 1'b1;
      wr_addr_d = faddr;
      wr_data_d = result;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_q <= wr_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // ----------------------------------------------------------------------
  // file registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= IOBX_FILE_RST;
      end
    end else if (wr_d && (int'(wr_addr_d) < FILE_DEPTH)) begin
      file_q[wr_addr_d] <= wr_data_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign instr_ready = ready_q;
  assign pc_out = pc_q;
  assign acc_out = acc_q;
  assign zero_flag = zero_q;
  assign file_wr_valid = wr_q;
  assign file_wr_addr = wr_addr_q;
  assign file_wr_data = wr_data_q;
  assign discard_pulse = disc_q;

endmodule

// >>> rtl/iobx_pkg.sv
// iobx_pkg: constants shared by the increment / or / jump execution block.
// assumes a 14-bit instruction word with the opcode in the upper bits.
package iobx_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int IOBX_DATA_W = 8;
  localparam int IOBX_FADDR_W = 7;
  localparam int IOBX_PC_W = 13;
  localparam int IOBX_INSTR_W = 14;
  localparam int IOBX_JUMP_W = 11;

  // ----------------------------------------------------------------------
  // instruction field positions
  // ----------------------------------------------------------------------
  localparam int IOBX_DEST_BIT = 7;
  localparam int IOBX_FADDR_LSB = 0;
  localparam int IOBX_LIT_LSB = 0;
  localparam int IOBX_JUMP_LSB = 0;
  localparam int IOBX_PAGE_LO = 3;
  localparam int IOBX_PAGE_HI = 4;

  // ----------------------------------------------------------------------
  // opcode patterns, matched under the masks below
  // ----------------------------------------------------------------------
  localparam logic [13:0] IOBX_MASK_FILE = 14'h3f00;
  localparam logic [13:0] IOBX_MASK_LIT = 14'h3f00;
  localparam logic [13:0] IOBX_MASK_JUMP = 14'h3800;
  localparam logic [13:0] IOBX_OP_INC_SKIP = 14'h0f00;
  localparam logic [13:0] IOBX_OP_INC_REG = 14'h0a00;
  localparam logic [13:0] IOBX_OP_OR_REG = 14'h0400;
  localparam logic [13:0] IOBX_OP_OR_LIT = 14'h3800;
  localparam logic [13:0] IOBX_OP_JUMP = 14'h2800;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] IOBX_ACC_RST = 8'h00;
  localparam logic IOBX_ZERO_RST = 1'b0;
  localparam logic [12:0] IOBX_PC_RST = 13'h0000;
  localparam logic [7:0] IOBX_FILE_RST = 8'h00;

  typedef enum logic [2:0] {
    IOBX_ALU_NONE,
    IOBX_ALU_INC,
    IOBX_ALU_OR_LIT,
    IOBX_ALU_OR_REG
  } iobx_alu_op_t;

endpackage

// >>> rtl/iobx_alu.sv
// iobx_alu: combinational result and zero detect for increment and or.
// assumes operands are stable within the cycle; no state of its own.
`timescale 1ns/10ps
module iobx_alu
  import iobx_pkg::*;
(
  input wire iobx_alu_op_t op,
  input wire logic [IOBX_DATA_W-1:0] acc,
  input wire logic [IOBX_DATA_W-1:0] fval,
  input wire logic [IOBX_DATA_W-1:0] lit,
  output logic [IOBX_DATA_W-1:0] result,
  output logic is_zero
);

  always_comb begin
    case (op)
      IOBX_ALU_INC: result = IOBX_DATA_W'(fval + 1'b1);
      IOBX_ALU_OR_LIT: result = acc | lit;
      IOBX_ALU_OR_REG: result = acc | fval;
      default: result = acc;
    endcase
    is_zero = (result == '0);
  end

endmodule

// >>> sim/iobx_props.sv
// iobx_props: port-level timing checks for the execution core.
// assumes it is bound to iobx_core and sees only its ports.
`timescale 1ns/10ps
module iobx_props
  import iobx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [IOBX_INSTR_W-1:0] instr,
  input wire logic [IOBX_DATA_W-1:0] pc_page_latch,
  input wire logic instr_ready,
  input wire logic [IOBX_PC_W-1:0] pc_out,
  input wire logic [IOBX_DATA_W-1:0] acc_out,
  input wire logic zero_flag,
  input wire logic file_wr_valid,
  input wire logic [IOBX_FADDR_W-1:0] file_wr_addr,
  input wire logic [IOBX_DATA_W-1:0] file_wr_data,
  input wire logic discard_pulse
);
  logic tk, kill, ex, isk, inc, orr, orl, jmp, j_q, s_q, d_q;
  assign tk = instr_valid && instr_ready;
  assign isk = (instr & IOBX_MASK_FILE) == IOBX_OP_INC_SKIP;
  assign inc = (instr & IOBX_MASK_FILE) == IOBX_OP_INC_REG;
  assign orr = (instr & IOBX_MASK_FILE) == IOBX_OP_OR_REG;
  assign orl = (instr & IOBX_MASK_LIT) == IOBX_OP_OR_LIT;
  assign jmp = (instr & IOBX_MASK_JUMP) == IOBX_OP_JUMP;
  // the skip result is read back from where the previous word left it
  assign kill = tk && (j_q || (s_q && ((d_q ? file_wr_data : acc_out) == 8'h00)));
  assign ex = tk && !kill;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      j_q <= 1'b0;
      s_q <= 1'b0;
      d_q <= 1'b0;
    end else if (tk) begin
      j_q <= ex && jmp;
      s_q <= ex && isk;
      d_q <= instr[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_skip_flag; ex && isk |=> $stable(zero_flag); endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("skip changed zero flag");
  property p_skip_dest; ex && isk && instr[7] |=> file_wr_valid && file_wr_addr == $past(instr[6:0]); endproperty
  a_skip_dest: assert property (p_skip_dest) else $error("skip result not written");
  property p_kill; kill |=> discard_pulse && pc_out == $past(pc_out) + 13'h1; endproperty
  a_kill: assert property (p_kill) else $error("word not discarded");
  property p_jump; ex && jmp |=> pc_out == {$past(pc_page_latch[4:3]), $past(instr[10:0])}; endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_orl; ex && orl |=> acc_out == ($past(acc_out) | $past(instr[7:0])) && zero_flag == (acc_out == 8'h00); endproperty
  a_orl: assert property (p_orl) else $error("or literal wrong");
  property p_inc_z; ex && inc && instr[7] |=> file_wr_valid && zero_flag == (file_wr_data == 8'h00); endproperty
  a_inc_z: assert property (p_inc_z) else $error("increment flag wrong");
  property p_orr; ex && orr && !instr[7] |=> (acc_out & $past(acc_out)) == $past(acc_out) && zero_flag == !acc_out; endproperty
  a_orr: assert property (p_orr) else $error("or register wrong");
  property p_no_wr; ex && !instr[7] && (isk || inc || orr) |=> !file_wr_valid; endproperty
  a_no_wr: assert property (p_no_wr) else $error("write with acc target");
  property p_kill_quiet; kill |=> !file_wr_valid && $stable(acc_out) && $stable(zero_flag); endproperty
  a_kill_quiet: assert property (p_kill_quiet) else $error("dropped word had an effect");
endmodule
bind iobx_core iobx_props i_props (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
  .pc_page_latch(pc_page_latch), .instr_ready(instr_ready), .pc_out(pc_out), .acc_out(acc_out),
  .zero_flag(zero_flag), .file_wr_valid(file_wr_valid), .file_wr_addr(file_wr_addr),
  .file_wr_data(file_wr_data), .discard_pulse(discard_pulse));

// >>> sim/tb_incr_or_branch_exec.sv
// tb_incr_or_branch_exec: directed and random streams against a reference model.
// assumes results show 1 ns after the taking edge, within the same cycle.
`timescale 1ns/10ps
module tb_incr_or_branch_exec;
  import iobx_pkg::*;
  localparam logic [13:0] DV [9] = '{14'h0481, 14'h38ff, 14'h0481, 14'h0f81, 14'h3801, 14'h2abc, 14'h38ff,
    14'h0a01, 14'h0f01};
  localparam logic [13:0] OPS [6] = '{IOBX_OP_INC_SKIP, IOBX_OP_INC_REG, IOBX_OP_OR_REG, IOBX_OP_OR_LIT,
    IOBX_OP_JUMP, 14'h3f00};
  localparam logic [13:0] MSK [6] = '{14'h0083, 14'h0083, 14'h0083, 14'h00ff, 14'h07ff, 14'h0000};
  logic clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, instr_ready, zero_flag, file_wr_valid, discard_pulse;
  logic [13:0] instr = 14'h0000;
  logic [7:0] pc_page_latch = 8'h00, acc_out, file_wr_data, acc, wd;
  logic [7:0] fm [128];
  logic [12:0] pc_out, pc;
  logic [6:0] file_wr_addr, wa;
  logic z, kill;
  logic [38:0] q [$];
  int error_cnt = 0, total_checks = 0, cyc = 0;
  iobx_core i_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .pc_page_latch(pc_page_latch), .instr_ready(instr_ready), .pc_out(pc_out), .acc_out(acc_out),
    .zero_flag(zero_flag), .file_wr_valid(file_wr_valid), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .discard_pulse(discard_pulse));
  initial forever #20 clk = ~clk;
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [38:0] e);
    logic [38:0] o;
    o = {pc_out, acc_out, zero_flag, file_wr_valid, file_wr_addr, file_wr_data, discard_pulse};
    total_checks++;
    if (o !== e) begin
      error_cnt++;
      $display("Error %0t state %h expected %h", $time, o, e);
    end
  endtask
  task automatic chk_rst();
    total_checks++;
    if ({instr_ready, pc_out, acc_out, zero_flag, file_wr_valid, discard_pulse} !== 25'h1000000) begin
      error_cnt++;
      $display("Error %0t reset state wrong", $time);
    end
  endtask
  task automatic send(input logic v, input logic [13:0] w);
    logic [7:0] r;
    logic f, wr, disc;
    @(negedge clk);
    instr_valid = v;
    instr = w;
    pc_page_latch = 8'($urandom);
    if (!v) return;
    f = 1'b1;
    wr = 1'b0;
    r = 8'h00;
    disc = kill;
    pc = pc + 13'h1;
    if (kill) kill = 1'b0;
    else if ((w & IOBX_MASK_JUMP) == IOBX_OP_JUMP) begin
      pc = {pc_page_latch[4:3], w[10:0]};
      kill = 1'b1;
    end else if ((w & IOBX_MASK_LIT) == IOBX_OP_OR_LIT) begin
      acc = acc | w[7:0];
      z = acc == 8'h00;
    end else begin
      case (w & IOBX_MASK_FILE)
        IOBX_OP_INC_SKIP: begin r = fm[w[6:0]] + 8'h01; kill = r == 8'h00; end
        IOBX_OP_INC_REG: begin r = fm[w[6:0]] + 8'h01; z = r == 8'h00; end
        IOBX_OP_OR_REG: begin r = acc | fm[w[6:0]]; z = r == 8'h00; end
        default: f = 1'b0;
      endcase
      if (f && w[7]) begin
        fm[w[6:0]] = r;
        {wr, wa, wd} = {1'b1, w[6:0], r};
      end else if (f) acc = r;
    end
    q.push_back({pc, acc, z, wr, wa, wd, disc});
  endtask
  // each reset is followed by the directed run, whose first word fixes the write port
  task automatic reset_run(input int n);
    send(1'b0, 14'h0000);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    {pc, acc, z, kill} = '0;
    foreach (fm[i]) fm[i] = 8'h00;
    @(negedge clk);
    chk_rst();
    foreach (DV[i]) send(1'b1, DV[i]);
    repeat (n) send(($urandom % 4) != 0, OPS[n % 6] | (14'($urandom) & MSK[n % 6]));
  endtask
  always @(posedge clk) begin : mon
    logic t;
    t = instr_valid === 1'b1 && instr_ready === 1'b1 && rst_n === 1'b1;
    #1;
    if (t) chk(q.size() > 0 ? q.pop_front() : 'x);
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 6000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(95));
    reset_run(0);
    for (int i = 0; i < 1500; i++) send(($urandom % 4) != 0, OPS[i % 6] | (14'($urandom) & MSK[i % 6]));
    reset_run(0);
    send(1'b0, 14'h0000);
    repeat (2) @(negedge clk);
    if (q.size() != 0) error_cnt++;
    give_verdict();
  end
endmodule
